// >>> link_cfg_top.sv
// Serial link channel selection, lane scaling, sync word and sync request detection.
// Assumes one 25 MHz clock that also serves as link clock and an AXI4-Lite master.
`timescale 1ns/1ps
`default_nettype none

module link_cfg_top
	import link_cfg_pkg::*;
#(
	parameter int SAMPLE_W = 12,
	parameter int MAX_LANES = 8
)
(
	input wire logic i_core_clk,
	input wire logic i_reset,
	// AXI4-Lite slave.
	input wire logic [link_cfg_pkg::ADDR_W-1:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [link_cfg_pkg::ADDR_W-1:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	// Sample stream, channels A to D from low to high.
	input wire logic [4*SAMPLE_W-1:0] i_sample_data,
	input wire logic i_sample_valid,
	output logic o_sample_ready,
	// Frame stream toward the lanes.
	output logic [4*SAMPLE_W-1:0] o_frame_data,
	output logic o_frame_valid,
	input wire logic i_frame_ready,
	output logic [MAX_LANES-1:0] o_lane_active,
	output logic o_tail_pad,
	output logic [31:0] o_sync_word,
	output logic o_sync_word_valid,
	// Sync request input, active low, and detected request.
	input wire logic i_sync_n,
	output logic o_sync_request
);
	import link_cfg_pkg::*;

	// ==========================================================
	// Registers
	logic [2:0] channel_enable_reg;
	logic [1:0] sync_header_select_reg;
	logic [THRESH_W-1:0] sync_request_count_reg;
	logic link_enable_reg;
	logic link_format_select_reg;
	logic [CNT_W-1:0] full_lane_count_reg;
	logic [CNT_W-1:0] full_converter_count_reg;
	logic [CNT_W-1:0] lane_count_reg;
	logic [CNT_W-1:0] converter_count_reg;
	logic [2:0] active_cfg_reg;
	logic link_enable_d_reg;
	logic [THRESH_W:0] low_run_reg;
	logic [11:0] crc_reg;
	logic [31:0] fec_reg;
	logic [5:0] word_cnt_reg;
	logic [4*SAMPLE_W-1:0] skid_data_reg;
	logic skid_valid_reg;
	logic wr_fire;
	logic rd_fire;
	logic [31:0] rd_value;
	logic rd_hit;
	logic wr_hit;
	logic [4*SAMPLE_W-1:0] mapped;
	logic [4*SAMPLE_W-1:0] in_word;
	logic in_take;
	logic out_take;
	logic half_mode;
	logic skid_valid_next;

	// Address decode used by both read and write paths.
	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		is_mapped = (a == byte_addr(CHANNEL_ENABLE_IDX)) || (a == byte_addr(SYNC_HEADER_SELECT_IDX))
			|| (a == byte_addr(SYNC_REQUEST_COUNT_IDX)) || (a == byte_addr(LINK_CONTROL_IDX))
			|| (a == byte_addr(LINK_STATUS_IDX));
	endfunction

	// One CRC-12 step over a whole frame word.
	function automatic logic [11:0] crc12_word(input logic [11:0] c, input logic [4*SAMPLE_W-1:0] d);
		logic [11:0] r;
		r = c;
		for (int i = 4*SAMPLE_W-1; i >= 0; i--)
		begin
			r = (r[11] ^ d[i]) ? ({r[10:0], 1'b0} ^ CRC12_POLY) : {r[10:0], 1'b0};
		end
		crc12_word = r;
	endfunction

	// ==========================================================
	// AXI4-Lite handshakes: address and data are taken together, one cycle ready pulses.
	assign wr_fire = o_awready;
	assign rd_fire = o_arready;
	assign wr_hit = is_mapped(i_awaddr);
	assign rd_hit = is_mapped(i_araddr);

	always_ff @(posedge i_core_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			o_awready <= 1'b0;
			o_wready <= 1'b0;
			o_bvalid <= 1'b0;
			o_bresp <= RESP_OKAY;
		end
		else
		begin
			o_awready <= i_awvalid && i_wvalid && !o_awready && !o_bvalid;
			o_wready <= i_awvalid && i_wvalid && !o_awready && !o_bvalid;
			if (wr_fire)
			begin
				o_bvalid <= 1'b1;
				o_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			else if (i_bready)
			begin
				o_bvalid <= 1'b0;
			end
		end
	end

	// Read channel; unmapped addresses answer SLVERR with zero data.
	always_ff @(posedge i_core_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			o_arready <= 1'b0;
			o_rvalid <= 1'b0;
			o_rdata <= 32'h0;
			o_rresp <= RESP_OKAY;
		end
		else
		begin
			o_arready <= i_arvalid && !o_arready && !o_rvalid;
			if (rd_fire)
			begin
				o_rvalid <= 1'b1;
				o_rdata <= rd_value;
				o_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
			else if (i_rready)
			begin
				o_rvalid <= 1'b0;
			end
		end
	end

	// Read multiplexer; reserved bits read as zero.
	always_comb
	begin
		rd_value = 32'h0;
		if (i_araddr == byte_addr(CHANNEL_ENABLE_IDX))
			rd_value[2:0] = channel_enable_reg;
		else if (i_araddr == byte_addr(SYNC_HEADER_SELECT_IDX))
			rd_value[1:0] = sync_header_select_reg;
		else if (i_araddr == byte_addr(SYNC_REQUEST_COUNT_IDX))
			rd_value[THRESH_W-1:0] = sync_request_count_reg;
		else if (i_araddr == byte_addr(LINK_CONTROL_IDX))
		begin
			rd_value[LINK_ENABLE_BIT] = link_enable_reg;
			rd_value[LINK_FORMAT_BIT] = link_format_select_reg;
			rd_value[FULL_LANE_LSB +: CNT_W] = full_lane_count_reg;
			rd_value[FULL_CONV_LSB +: CNT_W] = full_converter_count_reg;
		end
		else if (i_araddr == byte_addr(LINK_STATUS_IDX))
		begin
			rd_value[0] = i_sync_n;
			rd_value[1] = o_sync_request;
			rd_value[FULL_LANE_LSB +: CNT_W] = lane_count_reg;
			rd_value[FULL_CONV_LSB +: CNT_W] = converter_count_reg;
		end
	end

	// Register writes; only defined bits are stored, upper bits are dropped.
	always_ff @(posedge i_core_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			channel_enable_reg <= CHANNEL_ENABLE_RST;
			sync_header_select_reg <= SYNC_HEADER_RST;
			sync_request_count_reg <= SYNC_REQUEST_RST;
			link_enable_reg <= 1'b0;
			link_format_select_reg <= 1'b0;
			full_lane_count_reg <= FULL_LANE_RST;
			full_converter_count_reg <= FULL_CONV_RST;
		end
		else if (wr_fire)
		begin
			if (i_awaddr == byte_addr(CHANNEL_ENABLE_IDX) && i_wstrb[0])
				channel_enable_reg <= i_wdata[2:0];
			if (i_awaddr == byte_addr(SYNC_HEADER_SELECT_IDX) && i_wstrb[0])
				sync_header_select_reg <= i_wdata[1:0];
			if (i_awaddr == byte_addr(SYNC_REQUEST_COUNT_IDX) && i_wstrb[0])
				sync_request_count_reg <= i_wdata[THRESH_W-1:0];
			if (i_awaddr == byte_addr(LINK_CONTROL_IDX))
			begin
				if (i_wstrb[0])
				begin
					link_enable_reg <= i_wdata[LINK_ENABLE_BIT];
					link_format_select_reg <= i_wdata[LINK_FORMAT_BIT];
					full_lane_count_reg <= i_wdata[FULL_LANE_LSB +: CNT_W];
				end
				if (i_wstrb[1])
					full_converter_count_reg <= i_wdata[FULL_CONV_LSB +: CNT_W];
			end
		end
	end

	// ==========================================================
	// Lane and converter scaling, latched when the link is enabled.
	assign half_mode = !channel_enable_reg[FIRST_PAIR_BIT] || !channel_enable_reg[SECOND_PAIR_BIT]
		|| channel_enable_reg[ONE_CONV_BIT];

	always_ff @(posedge i_core_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			link_enable_d_reg <= 1'b0;
			lane_count_reg <= '0;
			converter_count_reg <= '0;
			active_cfg_reg <= CHANNEL_ENABLE_RST;
			o_tail_pad <= 1'b0;
			o_lane_active <= '0;
		end
		else
		begin
			link_enable_d_reg <= link_enable_reg;
			if (!link_enable_reg)
				o_lane_active <= '0;
			else if (!link_enable_d_reg)
			begin
				active_cfg_reg <= channel_enable_reg;
				if (half_mode)
				begin
					lane_count_reg <= CNT_W'((full_lane_count_reg + 4'd1) >> 1);
					converter_count_reg <= full_converter_count_reg >> 1;
					o_tail_pad <= full_lane_count_reg[0];
				end
				else
				begin
					lane_count_reg <= full_lane_count_reg;
					converter_count_reg <= full_converter_count_reg;
					o_tail_pad <= 1'b0;
				end
				for (int i = 0; i < MAX_LANES; i++)
				begin
					o_lane_active[i] <= half_mode
						? (i < ((32'(full_lane_count_reg) + 1) >> 1))
						: (i < 32'(full_lane_count_reg));
				end
			end
		end
	end

	// ==========================================================
	// Sample slot mapping from the latched channel configuration.
	always_comb
	begin
		mapped = '0;
		if (active_cfg_reg[ONE_CONV_BIT])
			mapped[0 +: SAMPLE_W] = i_sample_data[0 +: SAMPLE_W];
		else if (!active_cfg_reg[FIRST_PAIR_BIT])
			mapped[0 +: 2*SAMPLE_W] = i_sample_data[2*SAMPLE_W +: 2*SAMPLE_W];
		else if (!active_cfg_reg[SECOND_PAIR_BIT])
			mapped[0 +: 2*SAMPLE_W] = i_sample_data[0 +: 2*SAMPLE_W];
		else
			mapped = i_sample_data;
	end

	// ==========================================================
	// Two-entry buffer: output register plus skid register.
	assign in_take = i_sample_valid && o_sample_ready && link_enable_d_reg;
	assign out_take = o_frame_valid && i_frame_ready;
	assign in_word = skid_valid_reg ? skid_data_reg : mapped;
	// Skid entry occupancy after this edge; ready follows it so that no held word is overwritten.
	assign skid_valid_next = (o_frame_valid && !out_take) ? (skid_valid_reg || in_take)
		: (skid_valid_reg && in_take);

	always_ff @(posedge i_core_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			o_frame_data <= '0;
			o_frame_valid <= 1'b0;
			skid_data_reg <= '0;
			skid_valid_reg <= 1'b0;
			o_sample_ready <= 1'b0;
		end
		else
		begin
			if (!o_frame_valid || out_take)
			begin
				o_frame_valid <= skid_valid_reg || in_take;
				if (skid_valid_reg || in_take)
					o_frame_data <= in_word;
				if (skid_valid_reg && in_take)
					skid_data_reg <= mapped;
				else
					skid_valid_reg <= 1'b0;
			end
			else if (in_take)
			begin
				skid_data_reg <= mapped;
				skid_valid_reg <= 1'b1;
			end
			o_sample_ready <= link_enable_reg && !skid_valid_next;
		end
	end

	// ==========================================================
	// Multiblock sync word with a CRC-12 check above zero command fields, or a 32-bit FEC check.
	always_ff @(posedge i_core_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			crc_reg <= '0;
			fec_reg <= '0;
			word_cnt_reg <= '0;
			o_sync_word <= '0;
			o_sync_word_valid <= 1'b0;
		end
		else
		begin
			o_sync_word_valid <= 1'b0;
			if (!link_enable_reg || !link_format_select_reg)
			begin
				crc_reg <= '0;
				fec_reg <= '0;
				word_cnt_reg <= '0;
			end
			else if (out_take)
			begin
				if (word_cnt_reg == 6'(MB_WORDS - 1))
				begin
					word_cnt_reg <= '0;
					crc_reg <= '0;
					fec_reg <= '0;
					o_sync_word_valid <= 1'b1;
					if (sync_header_select_reg == SH_FEC)
						o_sync_word <= fec_reg ^ o_frame_data[31:0];
					else if (sync_header_select_reg == SH_CRC12)
						o_sync_word <= {crc12_word(crc_reg, o_frame_data), 20'h0};
					else
						o_sync_word <= 32'h0;
				end
				else
				begin
					word_cnt_reg <= word_cnt_reg + 6'd1;
					crc_reg <= crc12_word(crc_reg, o_frame_data);
					fec_reg <= {fec_reg[30:0], fec_reg[31]} ^ o_frame_data[31:0];
				end
			end
		end
	end

	// ==========================================================
	// Sync request detection: count consecutive low samples of the sync input.
	always_ff @(posedge i_core_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			low_run_reg <= '0;
			o_sync_request <= 1'b0;
		end
		else if (i_sync_n)
		begin
			low_run_reg <= '0;
			o_sync_request <= 1'b0;
		end
		else
		begin
			if (low_run_reg <= {1'b0, sync_request_count_reg})
				low_run_reg <= low_run_reg + 6'd1;
			if (low_run_reg >= {1'b0, sync_request_count_reg})
				o_sync_request <= 1'b1;
		end
	end

endmodule

`default_nettype wire

// >>> link_cfg_pkg.sv
// Package for the serial link channel and sync configuration block.
// Assumes a 32-bit AXI4-Lite register bus with one aligned word per register.
`default_nettype none

package link_cfg_pkg;

	// ==========================================================
	// Register indices and byte addresses
	localparam logic [11:0] CHANNEL_ENABLE_IDX = 12'h209;
	localparam logic [11:0] SYNC_HEADER_SELECT_IDX = 12'h20f;
	localparam logic [11:0] SYNC_REQUEST_COUNT_IDX = 12'h210;
	localparam logic [11:0] LINK_CONTROL_IDX = 12'h300;
	localparam logic [11:0] LINK_STATUS_IDX = 12'h301;
	localparam int ADDR_W = 14;

	function automatic logic [ADDR_W-1:0] byte_addr(input logic [11:0] idx);
		byte_addr = {idx, 2'b00};
	endfunction

	// ==========================================================
	// Field positions
	localparam int FIRST_PAIR_BIT = 0;
	localparam int SECOND_PAIR_BIT = 1;
	localparam int ONE_CONV_BIT = 2;
	localparam int LINK_ENABLE_BIT = 0;
	localparam int LINK_FORMAT_BIT = 1;
	localparam int FULL_LANE_LSB = 4;
	localparam int FULL_CONV_LSB = 8;
	localparam int CNT_W = 4;
	localparam int THRESH_W = 5;

	// ==========================================================
	// Reset values
	localparam logic [2:0] CHANNEL_ENABLE_RST = 3'h3;
	localparam logic [1:0] SYNC_HEADER_RST = 2'h0;
	localparam logic [THRESH_W-1:0] SYNC_REQUEST_RST = 5'h03;
	localparam logic [CNT_W-1:0] FULL_LANE_RST = 4'h8;
	localparam logic [CNT_W-1:0] FULL_CONV_RST = 4'h4;

	// ==========================================================
	// Sync word encodings and timing
	localparam logic [1:0] SH_CRC12 = 2'h0;
	localparam logic [1:0] SH_FEC = 2'h2;
	localparam logic [11:0] CRC12_POLY = 12'h80f;
	localparam int MB_WORDS = 32;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

`default_nettype wire

// >>> link_cfg_asserts.sv
// Port checks for the link configuration block.
// Assumes one clock domain with an asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

// ==========
// Checker
module link_cfg_asserts
#(
	parameter int SAMPLE_W = 12
)
(
	input wire logic i_core_clk,
	input wire logic i_reset,
	input wire logic o_awready,
	input wire logic o_wready,
	input wire logic o_bvalid,
	input wire logic [1:0] o_bresp,
	input wire logic i_bready,
	input wire logic o_arready,
	input wire logic o_rvalid,
	input wire logic [31:0] o_rdata,
	input wire logic i_rready,
	input wire logic i_sample_valid,
	input wire logic o_sample_ready,
	input wire logic [4*SAMPLE_W-1:0] o_frame_data,
	input wire logic o_frame_valid,
	input wire logic i_frame_ready,
	input wire logic i_sync_n,
	input wire logic o_sync_request
);
	// Every check runs on the core clock and is silent in reset.
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_reset);

	// Address and data are taken together and answered one cycle later.
	property p_write_answer; o_awready |-> o_wready ##1 o_bvalid; endproperty
	a_write_answer: assert property (p_write_answer) else $error("write answer late");
	property p_read_answer; o_arready |=> o_rvalid; endproperty
	a_read_answer: assert property (p_read_answer) else $error("read answer late");
	property p_ready_pulse; o_awready |=> !o_awready; endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("write ready not a pulse");
	// Answers and frames stand until the other side takes them.
	property p_bresp_hold; o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp); endproperty
	a_bresp_hold: assert property (p_bresp_hold) else $error("write answer dropped");
	property p_rdata_hold; o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata); endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read answer dropped");
	property p_frame_hold;
		o_frame_valid && !i_frame_ready |=> o_frame_valid && $stable(o_frame_data);
	endproperty
	a_frame_hold: assert property (p_frame_hold) else $error("frame dropped in stall");
	property p_frame_next; i_sample_valid && o_sample_ready |=> o_frame_valid; endproperty
	a_frame_next: assert property (p_frame_next) else $error("frame not offered");
	// A request needs low samples and ends one cycle after the line rises.
	property p_sync_drop; i_sync_n |=> !o_sync_request; endproperty
	a_sync_drop: assert property (p_sync_drop) else $error("request outlived high sync");
	property p_sync_low; $rose(o_sync_request) |-> $past(!i_sync_n, 1); endproperty
	a_sync_low: assert property (p_sync_low) else $error("request without low sync");
endmodule

bind link_cfg_top link_cfg_asserts #(.SAMPLE_W(SAMPLE_W)) link_cfg_asserts_i (.i_core_clk,
	.i_reset, .o_awready, .o_wready, .o_bvalid, .o_bresp, .i_bready, .o_arready, .o_rvalid,
	.o_rdata, .i_rready, .i_sample_valid, .o_sample_ready, .o_frame_data, .o_frame_valid,
	.i_frame_ready, .i_sync_n, .o_sync_request);

`default_nettype wire

// >>> far_receiver_model.sv
// Model of the link receiver: frame ready and the active-low sync line.
// Assumes the bench picks the ready mode and starts sync pulses.
`timescale 1ns/1ps
`default_nettype none

// ==========
// Receiver
module far_receiver_model
(
	input wire logic i_core_clk,
	input wire logic i_reset,
	input wire logic [1:0] i_mode,
	input wire logic i_sync_go,
	input wire logic [7:0] i_sync_len,
	output logic o_frame_ready,
	output logic o_sync_n
);
	logic phase_reg;
	logic [7:0] low_reg;

	// Mode 0 takes every frame, 1 every other cycle, 2 stalls.
	always_ff @(posedge i_core_clk or posedge i_reset)
		if (i_reset)
			phase_reg <= 1'b0;
		else
			phase_reg <= ~phase_reg;
	assign o_frame_ready = (i_mode == 2'h0) || (i_mode == 2'h1 && phase_reg);

	// Holds sync low for the asked number of cycles, then releases it high.
	always_ff @(posedge i_core_clk or posedge i_reset)
		if (i_reset)
			low_reg <= 8'h00;
		else if (i_sync_go)
			low_reg <= i_sync_len;
		else if (low_reg != 8'h00)
			low_reg <= low_reg - 8'h01;
	assign o_sync_n = (low_reg == 8'h00);
endmodule

`default_nettype wire

// >>> testbench.sv
// Bench for the link configuration block: bus tasks, streams and sync.
// Assumes the checker is bound and the receiver model drives the far side.
`timescale 1ns/1ps
`default_nettype none

// ==========
// Bench
module testbench;
	import link_cfg_pkg::*;
	logic i_core_clk = 1'b0, i_reset = 1'b1;
	logic [ADDR_W-1:0] i_awaddr = '0, i_araddr = '0;
	logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
	logic [31:0] i_wdata = '0;
	logic [3:0] i_wstrb = 4'hf;
	logic [47:0] i_sample_data = '0;
	logic i_sample_valid = 1'b0, sync_go = 1'b0, refused;
	logic [1:0] mode = 2'h0;
	logic [7:0] sync_len = 8'h00;
	wire logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_sample_ready, o_frame_valid;
	wire logic i_frame_ready, o_tail_pad, o_sync_word_valid, i_sync_n, o_sync_request;
	wire logic [1:0] o_bresp, o_rresp;
	wire logic [31:0] o_rdata, o_sync_word;
	wire logic [47:0] o_frame_data;
	wire logic [7:0] o_lane_active;
	int miscompares = 0, compares = 0, pulses = 0, p;
	logic [47:0] got[$];
	logic [2:0] chs[4] = '{3'h3, 3'h1, 3'h2, 3'h5};
	logic [3:0] lns[4] = '{4'h8, 4'h8, 4'h7, 4'h8};
	logic [7:0] lanes[4] = '{8'hff, 8'h0f, 8'h0f, 8'h0f};
	logic [47:0] msk[4] = '{48'hffffffffffff, 48'hffffff, 48'hffffff, 48'hfff};

	link_cfg_top link_cfg_top_i (.i_core_clk, .i_reset, .i_awaddr, .i_awvalid, .o_awready,
		.i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr,
		.i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_sample_data,
		.i_sample_valid, .o_sample_ready, .o_frame_data, .o_frame_valid, .i_frame_ready,
		.o_lane_active, .o_tail_pad, .o_sync_word, .o_sync_word_valid, .i_sync_n, .o_sync_request);
	far_receiver_model far_receiver_model_i (.i_core_clk, .i_reset, .i_mode(mode),
		.i_sync_go(sync_go), .i_sync_len(sync_len), .o_frame_ready(i_frame_ready),
		.o_sync_n(i_sync_n));

	// Clock and the records of frames and sync word pulses.
	initial forever #20 i_core_clk = ~i_core_clk;
	always @(posedge i_core_clk)
	begin
		if (o_frame_valid && i_frame_ready)
			got.push_back(o_frame_data);
		if (o_sync_word_valid)
			pulses++;
	end

	task automatic end_of_test();
		if (miscompares == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
		compares++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic limit(input int n);
		if (n >= 80)
		begin
			miscompares++;
			$display("BAD %0t wait ran out", $time);
			end_of_test();
		end
	endtask

	task automatic wr(input logic [11:0] idx, input logic [31:0] d, input logic [1:0] r);
		int n;
		n = 0;
		i_awaddr <= {idx, 2'b00};
		i_wdata <= d;
		{i_awvalid, i_wvalid, i_bready} <= 3'b111;
		do
		begin
			@(posedge i_core_clk);
			n++;
			if (o_awready)
				{i_awvalid, i_wvalid} <= 2'b00;
		end while (!o_bvalid && n < 80);
		limit(n);
		chk(o_bresp, r);
		i_bready <= 1'b0;
		@(posedge i_core_clk);
	endtask

	task automatic rchk(input logic [11:0] idx, input logic [31:0] d, input logic [1:0] r);
		int n;
		n = 0;
		i_araddr <= {idx, 2'b00};
		{i_arvalid, i_rready} <= 2'b11;
		do
		begin
			@(posedge i_core_clk);
			n++;
			if (o_arready)
				i_arvalid <= 1'b0;
		end while (!o_rvalid && n < 80);
		limit(n);
		chk({o_rresp, o_rdata}, {r, d});
		i_rready <= 1'b0;
		@(posedge i_core_clk);
	endtask

	function automatic logic [47:0] word(input int k);
		word = {4{12'(k)}} | 48'h400300200100;
	endfunction

	// CRC-12 over one multiblock of burst words, first bit first, above zero command fields.
	function automatic logic [31:0] crc_exp();
		logic [11:0] c;
		logic [47:0] d;
		c = '0;
		for (int k = 0; k < MB_WORDS; k++)
		begin
			d = word(k);
			for (int i = 47; i >= 0; i--)
				c = (c[11] ^ d[i]) ? ({c[10:0], 1'b0} ^ CRC12_POLY) : {c[10:0], 1'b0};
		end
		crc_exp = {c, 20'h0};
	endfunction

	// Pushes n words while the receiver first stalls, then drains slowly.
	task automatic burst(input int n);
		int w;
		got.delete();
		refused = 1'b0;
		mode <= 2'h2;
		fork
			begin
				repeat (10) @(posedge i_core_clk);
				mode <= 2'h1;
			end
		join_none
		for (int k = 0; k < n; k++)
		begin
			i_sample_data <= word(k);
			i_sample_valid <= 1'b1;
			w = 0;
			do
			begin
				@(posedge i_core_clk);
				w++;
				refused |= !o_sample_ready;
			end while (!o_sample_ready && w < 80);
			limit(w);
		end
		i_sample_valid <= 1'b0;
		for (w = 0; got.size() < n && w < 80; w++)
			@(posedge i_core_clk);
		limit(w);
		chk(refused, 1'b1);
		mode <= 2'h0;
	endtask

	task automatic cfg(input logic [2:0] ch, input logic [3:0] ln, input logic fmt);
		wr(LINK_CONTROL_IDX, {20'h0, 4'h4, ln, 2'b00, fmt, 1'b0}, RESP_OKAY);
		chk(o_lane_active, 8'h00);
		wr(CHANNEL_ENABLE_IDX, {29'h0, ch}, RESP_OKAY);
		wr(LINK_CONTROL_IDX, {20'h0, 4'h4, ln, 2'b00, fmt, 1'b1}, RESP_OKAY);
		repeat (2) @(posedge i_core_clk);
	endtask

	task automatic sync_try(input logic [7:0] len, input logic exp);
		logic seen;
		seen = 1'b0;
		sync_len <= len;
		sync_go <= 1'b1;
		@(posedge i_core_clk);
		sync_go <= 1'b0;
		repeat (len + 6)
		begin
			@(posedge i_core_clk);
			seen |= o_sync_request;
		end
		chk(seen, exp);
	endtask

	// Main sequence: registers, lane scaling and mapping, sync word, sync requests.
	initial
	begin
		repeat (2) @(posedge i_core_clk);
		i_reset <= 1'b0;
		@(posedge i_core_clk);
		rchk(CHANNEL_ENABLE_IDX, 32'h3, RESP_OKAY);
		rchk(SYNC_HEADER_SELECT_IDX, 32'h0, RESP_OKAY);
		rchk(SYNC_REQUEST_COUNT_IDX, 32'h3, RESP_OKAY);
		rchk(12'h0ff, 32'h0, RESP_SLVERR);
		wr(12'h0ff, 32'h1, RESP_SLVERR);
		for (int t = 0; t < 4; t++)
		begin
			cfg(chs[t], lns[t], 1'b0);
			chk(o_lane_active, lanes[t]);
			chk(o_tail_pad, t == 2);
			burst(4);
			for (int k = 0; k < 4; k++)
				chk(got[k], (word(k) >> (t == 2 ? 24 : 0)) & msk[t]);
		end
		wr(LINK_CONTROL_IDX, 32'h0, RESP_OKAY);
		wr(SYNC_HEADER_SELECT_IDX, {30'h0, SH_FEC}, RESP_OKAY);
		rchk(SYNC_HEADER_SELECT_IDX, {30'h0, SH_FEC}, RESP_OKAY);
		cfg(3'h3, 4'h8, 1'b1);
		p = pulses;
		burst(32);
		repeat (2) @(posedge i_core_clk);
		chk(48'(pulses - p), 48'h1);
		chk(48'(o_sync_word == crc_exp()), 48'h0);
		wr(LINK_CONTROL_IDX, 32'h0, RESP_OKAY);
		wr(SYNC_HEADER_SELECT_IDX, {30'h0, SH_CRC12}, RESP_OKAY);
		cfg(3'h3, 4'h8, 1'b1);
		burst(32);
		repeat (2) @(posedge i_core_clk);
		chk(o_sync_word, crc_exp());
		cfg(3'h3, 4'h8, 1'b0);
		p = pulses;
		burst(32);
		repeat (2) @(posedge i_core_clk);
		chk(48'(pulses - p), 48'h0);
		sync_try(8'h03, 1'b0);
		sync_try(8'h04, 1'b1);
		wr(SYNC_REQUEST_COUNT_IDX, 32'h0, RESP_OKAY);
		rchk(SYNC_REQUEST_COUNT_IDX, 32'h0, RESP_OKAY);
		sync_try(8'h01, 1'b1);
		end_of_test();
	end
endmodule

`default_nettype wire
